//--- camif_defines.svh
// Register map, field positions and reset values of the camera input front end.
// Assumes inclusion from the package, the front-end module and the bench only.
// Behaviour
// - Source format bit 31: 1 separate-sync 8/16-bit input, 0 embedded-sync 8-bit.
// - Chroma offset bit 30 set adds 128 to every Cb and Cr value.
// - Bit 29 enables 16-bit input, chroma on its own lane.
// - Bits 15:14 set component order for 8-bit input; only bit 14 (Cb/Cr order) acts on 16-bit input.
// - Window offset enable bit 31 applies horizontal and vertical offsets.
// - Horizontal window skips bits 26:16 pixels; software keeps it a multiple of 8.
// - Vertical window skips the line count held in bits 10:0.
// - Writing 1 to bits 30, 15, 14 clears codec Y, Cb, Cr overflow flags.
// - Writing 1 to bits 13, 12 clears preview Cb, Cr overflow flags.
// - Global control bit 31 holds capture logic in reset while set.
// - Global control bit 30 drives the camera reset line directly.
// - Bits 28:27 choose camera data or one of three test patterns, max 1280x1024, in 8-bit separate-sync mode only.
// - Bit 26 clear samples on rising pixel clock edge, set on falling edge.
// - Bit 25 inverts incoming vertical sync polarity.
// - Bit 24 inverts incoming horizontal reference polarity.
// - Embedded mode detects FF 00 00 then decodes F, V, H bits.
// - New capture commands take effect only at vertical sync falling edge.
`ifndef CAMIF_DEFINES_SVH
`define CAMIF_DEFINES_SVH
`define ADDR_SOURCE_FORMAT   32'h4800_0000
`define ADDR_WINDOW_OFFSET   32'h4800_0004
`define ADDR_GLOBAL_CONTROL  32'h4800_0008
`define ADDR_CAPTURE_CONTROL 32'h4800_000c
`define ADDR_STATUS          32'h4800_0010
`define RST_SOURCE_FORMAT    32'h0000_0000
`define RST_WINDOW_OFFSET    32'h0000_0000
`define RST_GLOBAL_CONTROL   32'h2000_0000
`define MASK_SOURCE_FORMAT   32'hffff_dfff
`define MASK_WINDOW_OFFSET   32'hc7ff_f7ff
`define MASK_GLOBAL_CONTROL  32'hdf00_0000
`define FIX_GLOBAL_CONTROL   32'h2000_0000
`define SF_STD_BIT      31
`define SF_CHROMA_OFS   30
`define SF_WIDE_BIT     29
`define SF_ORDER_HI     15
`define SF_ORDER_LO     14
`define WO_EN_BIT       31
`define WO_CLR_CO_Y     30
`define WO_H_HI         26
`define WO_H_LO         16
`define WO_CLR_CO_CB    15
`define WO_CLR_CO_CR    14
`define WO_CLR_PR_CB    13
`define WO_CLR_PR_CR    12
`define WO_V_HI         10
`define GC_SOFT_RST     31
`define GC_CAM_RST      30
`define GC_PAT_HI       28
`define GC_PAT_LO       27
`define GC_PCLK_INV     26
`define GC_VSYNC_INV    25
`define GC_HREF_INV     24
`define PAT_MAX_W       13'd1280
`define PAT_MAX_H       13'd1024
`define CHROMA_OFFSET   8'h80
`define CHROMA_NEUTRAL  8'h80
`endif

//--- camif_pkg.sv
// Types shared by the camera input front end.
// Assumes the defines header sits in the same folder.
`include "camif_defines.svh"
package camif_pkg;
  typedef enum logic [1:0] {
    SYN_IDLE = 2'b00,
    SYN_FF   = 2'b01,
    SYN_Z1   = 2'b11,
    SYN_Z2   = 2'b10
  } sync_state_e;
  typedef enum logic [1:0] {
    PAT_CAMERA = 2'b00,
    PAT_BARS   = 2'b01,
    PAT_HINC   = 2'b10,
    PAT_VINC   = 2'b11
  } pattern_e;
  typedef logic [31:0] word_t;
endpackage

//--- camera_input_frontend_config.sv
// Camera pixel input front end: APB register file, sync recovery, ordering, windowing, test patterns.
// Assumes an APB master on clock_i and a camera whose pixel clock is slower than clock_i.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "camif_defines.svh"
module camera_input_frontend_config (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [31:0]          paddr_i,
  input  wire camif_pkg::word_t     pwdata_i,
  output camif_pkg::word_t          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic                 cam_pixel_clock_i,
  input  wire logic                 cam_vertical_sync_i,
  input  wire logic                 cam_line_valid_i,
  input  wire logic [7:0]           cam_luma_lane_i,
  input  wire logic [7:0]           cam_chroma_lane_i,
  input  wire logic [4:0]           ovf_event_i,
  output logic                      cam_reset_out_o,
  output logic                      iface_soft_reset_o,
  output logic                      frame_start_o,
  output logic                      pix_y_vld_o,
  output logic [7:0]                pix_y_o,
  output logic                      pix_c_vld_o,
  output logic [7:0]                pix_c_o,
  output logic                      pix_c_is_cr_o
);
  import camif_pkg::*;

  // Order bit 1 set puts chroma first; phase 0 is the first byte of a pair
  function automatic logic comp_is_y(input logic [1:0] ord, input logic [1:0] ph);
    comp_is_y = ~(ph[0] ^ ord[1]);
  endfunction

  function automatic logic comp_is_cr(input logic [1:0] ord, input logic [1:0] ph, input logic wide);
    comp_is_cr = wide ? (ph[0] ^ ord[0]) : (ph[1] ^ ord[0]);
  endfunction

  function automatic logic [7:0] pattern_luma(input pattern_e sel, input logic [12:0] x, input logic [12:0] y);
    logic [7:0] bar;
    bar = 8'h00;
    case (x[7:5])
      3'h0:    bar = 8'heb;
      3'h1:    bar = 8'hd2;
      3'h2:    bar = 8'ha9;
      3'h3:    bar = 8'h90;
      3'h4:    bar = 8'h6a;
      3'h5:    bar = 8'h51;
      3'h6:    bar = 8'h29;
      default: bar = 8'h10;
    endcase
    case (sel)
      PAT_BARS: pattern_luma = bar;
      PAT_HINC: pattern_luma = x[7:0];
      PAT_VINC: pattern_luma = y[7:0];
      default:  pattern_luma = 8'h00;
    endcase
  endfunction

  // Register file
  word_t       src_fmt_q;
  word_t       win_q;
  word_t       gctl_q;
  logic        cap_en_q;
  logic [4:0]  ovf_q;
  logic        pready_q;
  logic        pslverr_q;
  word_t       prdata_q;

  wire         apb_access = psel_i & penable_i;
  wire         apb_done   = apb_access & pready_q;
  wire         apb_wr     = apb_done & pwrite_i;
  wire         hit_fmt    = (paddr_i == `ADDR_SOURCE_FORMAT);
  wire         hit_win    = (paddr_i == `ADDR_WINDOW_OFFSET);
  wire         hit_gctl   = (paddr_i == `ADDR_GLOBAL_CONTROL);
  wire         hit_cap    = (paddr_i == `ADDR_CAPTURE_CONTROL);
  wire         hit_stat   = (paddr_i == `ADDR_STATUS);
  wire         hit_any    = hit_fmt | hit_win | hit_gctl | hit_cap | hit_stat;
  wire         soft_rst   = gctl_q[`GC_SOFT_RST];
  // Clear bits act as levels: a flag shows only the previous cycle's event until software writes the bit back to zero
  wire [4:0]   ovf_clr    = {win_q[`WO_CLR_CO_Y], win_q[`WO_CLR_CO_CB], win_q[`WO_CLR_CO_CR],
                             win_q[`WO_CLR_PR_CB], win_q[`WO_CLR_PR_CR]};
  wire [4:0]   ovf_d      = ovf_event_i | (ovf_q & ~ovf_clr);
  logic        vsync_eff_q;
  logic        field_q;
  word_t       stat_word;
  word_t       rd_word;

  assign stat_word = {22'h0, field_q, vsync_eff_q, 3'h0, ovf_q};
  assign rd_word   = hit_fmt  ? src_fmt_q :
                     hit_win  ? win_q :
                     hit_gctl ? gctl_q :
                     hit_cap  ? {31'h0, cap_en_q} :
                     hit_stat ? stat_word : 32'h0;

  // Every access takes one wait state, so read data is settled before completion
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= apb_access & ~pready_q;
      pslverr_q <= apb_access & ~pready_q & ~hit_any;
      prdata_q  <= (apb_access & ~pready_q & ~pwrite_i) ? rd_word : 32'h0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_fmt_q <= `RST_SOURCE_FORMAT;
      win_q     <= `RST_WINDOW_OFFSET;
      gctl_q    <= `RST_GLOBAL_CONTROL;
      cap_en_q  <= 1'b0;
      ovf_q     <= 5'h0;
    end else begin
      ovf_q <= ovf_d;
      if (apb_wr && hit_fmt) begin
        src_fmt_q <= pwdata_i & `MASK_SOURCE_FORMAT;
      end
      if (apb_wr && hit_win) begin
        win_q <= pwdata_i & `MASK_WINDOW_OFFSET;
      end
      if (apb_wr && hit_gctl) begin
        gctl_q <= (pwdata_i & `MASK_GLOBAL_CONTROL) | `FIX_GLOBAL_CONTROL;
      end
      if (apb_wr && hit_cap) begin
        cap_en_q <= pwdata_i[0];
      end
    end
  end

  // Pin synchronisers; data rides the same two stages so it stays aligned with the clock edge
  logic [18:0] pin_s1_q;
  logic [18:0] pin_s2_q;
  logic        pclk_prev_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q    <= 19'h0;
      pin_s2_q    <= 19'h0;
      pclk_prev_q <= 1'b0;
    end else begin
      pin_s1_q    <= {cam_pixel_clock_i, cam_vertical_sync_i, cam_line_valid_i, cam_luma_lane_i, cam_chroma_lane_i};
      pin_s2_q    <= pin_s1_q;
      pclk_prev_q <= pin_s2_q[18];
    end
  end

  wire         pclk_s   = pin_s2_q[18] ^ gctl_q[`GC_PCLK_INV];
  wire         pclk_p   = pclk_prev_q ^ gctl_q[`GC_PCLK_INV];
  wire         pix_edge = pclk_s & ~pclk_p;
  wire         vs_601   = pin_s2_q[17] ^ gctl_q[`GC_VSYNC_INV];
  wire         hr_601   = pin_s2_q[16] ^ gctl_q[`GC_HREF_INV];
  wire [7:0]   luma_b   = pin_s2_q[15:8];
  wire [7:0]   chroma_b = pin_s2_q[7:0];

  // Capture state, shadows loaded at frame start
  sync_state_e syn_q;
  logic        vblank_q;
  logic        active_q;
  logic        line_q;
  logic [1:0]  ph_q;
  logic [12:0] x_q;
  logic [12:0] y_q;
  word_t       sh_fmt_q;
  word_t       sh_win_q;
  logic [1:0]  sh_pat_q;
  logic        sh_cap_q;

  wire         std_601   = sh_fmt_q[`SF_STD_BIT];
  wire         wide      = sh_fmt_q[`SF_WIDE_BIT] & std_601;
  wire [1:0]   order     = sh_fmt_q[`SF_ORDER_HI:`SF_ORDER_LO];
  // Vertical sync source follows the live register, line source the shadow: the shadow loads only at a sync fall found through it
  wire         std_live  = src_fmt_q[`SF_STD_BIT];
  wire         vs_now    = std_live ? vs_601 : vblank_q;
  wire         line_now  = std_601 ? hr_601 : active_q;
  wire         vs_fall   = vsync_eff_q & ~vs_now;
  wire         line_fall = line_q & ~line_now;
  wire         is_y      = wide | comp_is_y(order, ph_q);
  wire         is_cr     = comp_is_cr(order, ph_q, wide);
  wire [12:0]  h_ofs     = {2'b00, sh_win_q[`WO_H_HI:`WO_H_LO]};
  wire [12:0]  v_ofs     = {2'b00, sh_win_q[`WO_V_HI:0]};
  wire         in_win    = ~sh_win_q[`WO_EN_BIT] | ((x_q >= h_ofs) & (y_q >= v_ofs));
  wire         pat_on    = (sh_pat_q != PAT_CAMERA) & std_601 & ~wide;
  wire         pat_in    = (x_q < `PAT_MAX_W) & (y_q < `PAT_MAX_H);
  wire         take      = pix_edge & line_now & sh_cap_q & in_win & (~pat_on | pat_in);
  wire [7:0]   y_sel     = pat_on ? pattern_luma(pattern_e'(sh_pat_q), x_q, y_q) : luma_b;
  wire [7:0]   c_raw     = pat_on ? `CHROMA_NEUTRAL : (wide ? chroma_b : luma_b);
  wire [7:0]   c_sel     = sh_fmt_q[`SF_CHROMA_OFS] ? c_raw + `CHROMA_OFFSET : c_raw;

  // Embedded timing code detector on the luma lane
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn_q    <= SYN_IDLE;
      vblank_q <= 1'b0;
      active_q <= 1'b0;
      field_q  <= 1'b0;
    end else if (soft_rst) begin
      syn_q    <= SYN_IDLE;
      vblank_q <= 1'b0;
      active_q <= 1'b0;
      field_q  <= 1'b0;
    end else if (pix_edge) begin
      case (syn_q)
        SYN_IDLE: syn_q <= (luma_b == 8'hff) ? SYN_FF : SYN_IDLE;
        SYN_FF:   syn_q <= (luma_b == 8'h00) ? SYN_Z1 : ((luma_b == 8'hff) ? SYN_FF : SYN_IDLE);
        SYN_Z1:   syn_q <= (luma_b == 8'h00) ? SYN_Z2 : SYN_IDLE;
        SYN_Z2: begin
          syn_q    <= SYN_IDLE;
          field_q  <= luma_b[6];
          vblank_q <= luma_b[5];
          active_q <= ~luma_b[4] & ~luma_b[5];
        end
        default: syn_q <= SYN_IDLE;
      endcase
    end
  end

  // Shadows follow the registers only at vertical sync fall, so a frame never changes midway
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_fmt_q <= `RST_SOURCE_FORMAT;
      sh_win_q <= `RST_WINDOW_OFFSET;
      sh_pat_q <= 2'b00;
      sh_cap_q <= 1'b0;
    end else if (soft_rst) begin
      sh_cap_q <= 1'b0;
    end else if (vs_fall) begin
      sh_fmt_q <= src_fmt_q;
      sh_win_q <= win_q;
      sh_pat_q <= gctl_q[`GC_PAT_HI:`GC_PAT_LO];
      sh_cap_q <= cap_en_q;
    end
  end

  // Position counters: x counts luma samples, y counts completed lines
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vsync_eff_q <= 1'b0;
      line_q      <= 1'b0;
      ph_q        <= 2'b00;
      x_q         <= 13'h0;
      y_q         <= 13'h0;
    end else if (soft_rst) begin
      vsync_eff_q <= 1'b0;
      line_q      <= 1'b0;
      ph_q        <= 2'b00;
      x_q         <= 13'h0;
      y_q         <= 13'h0;
    end else begin
      vsync_eff_q <= vs_now;
      line_q      <= line_now;
      if (vs_fall) begin
        y_q <= 13'h0;
      end else if (line_fall) begin
        y_q <= y_q + 13'h1;
      end
      if (!line_now) begin
        ph_q <= 2'b00;
        x_q  <= 13'h0;
      end else if (pix_edge) begin
        ph_q <= ph_q + 2'b01;
        if (is_y) begin
          x_q <= x_q + 13'h1;
        end
      end
    end
  end

  // Output stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cam_reset_out_o    <= 1'b0;
      iface_soft_reset_o <= 1'b0;
      frame_start_o      <= 1'b0;
      pix_y_vld_o        <= 1'b0;
      pix_y_o            <= 8'h00;
      pix_c_vld_o        <= 1'b0;
      pix_c_o            <= 8'h00;
      pix_c_is_cr_o      <= 1'b0;
    end else begin
      cam_reset_out_o    <= gctl_q[`GC_CAM_RST];
      iface_soft_reset_o <= soft_rst;
      frame_start_o      <= vs_fall & ~soft_rst;
      pix_y_vld_o        <= take & is_y & ~soft_rst;
      pix_c_vld_o        <= take & (wide | ~is_y) & ~soft_rst;
      if (take) begin
        pix_y_o       <= y_sel;
        pix_c_o       <= c_sel;
        pix_c_is_cr_o <= is_cr;
      end
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
endmodule

//--- camif_fe_properties.sv
// Concurrent checks on the camera front end ports: bus answer timing, control lines, pixel pulses.
// Assumes clock_i at 200 MHz and a pixel clock far slower; bound by the statement at the foot.
`timescale 1ns/1ps
module camif_fe_checker (
  input wire logic             clock_i,
  input wire logic             rst_n_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [31:0]      paddr_i,
  input wire camif_pkg::word_t pwdata_i,
  input wire camif_pkg::word_t prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  input wire logic             cam_reset_out_o,
  input wire logic             iface_soft_reset_o,
  input wire logic             frame_start_o,
  input wire logic             pix_y_vld_o,
  input wire logic             pix_c_vld_o
);
  import camif_pkg::*;
  wire logic acc   = psel_i && penable_i && pready_o;
  wire logic gc_wr = acc && pwrite_i && paddr_i == 32'h4800_0008;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_ready_late; psel_i && !penable_i |=> !pready_o ##1 pready_o; endproperty
  a_ready_late: assert property (p_ready_late)
    else $error("pready not in second access cycle");
  property p_err_map;
    acc |-> pslverr_o == !(paddr_i inside {32'h4800_0000, 32'h4800_0004, 32'h4800_0008, 32'h4800_000c,
                                           32'h4800_0010});
  endproperty
  a_err_map: assert property (p_err_map) else $error("slave error does not match address map");
  property p_rdata_idle; !(acc && !pwrite_i) |-> prdata_o == '0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read completion");
  property p_gc_fixed; acc && !pwrite_i && paddr_i == 32'h4800_0008 |-> prdata_o[29]; endproperty
  a_gc_fixed: assert property (p_gc_fixed) else $error("reserved control bit reads zero");
  property p_cam_rst; gc_wr |-> ##2 cam_reset_out_o == $past(pwdata_i[30], 2); endproperty
  a_cam_rst: assert property (p_cam_rst) else $error("camera reset line not following register");
  property p_soft_out; gc_wr |-> ##2 iface_soft_reset_o == $past(pwdata_i[31], 2); endproperty
  a_soft_out: assert property (p_soft_out) else $error("soft reset line not following register");
  property p_soft_quiet; iface_soft_reset_o [*3] |-> !pix_y_vld_o && !pix_c_vld_o; endproperty
  a_soft_quiet: assert property (p_soft_quiet) else $error("pixel output during soft reset");
  property p_fs_pulse; $rose(frame_start_o) |=> $fell(frame_start_o); endproperty
  a_fs_pulse: assert property (p_fs_pulse) else $error("frame start longer than one cycle");
  property p_pix_gap; pix_y_vld_o |=> !pix_y_vld_o [*8]; endproperty
  a_pix_gap: assert property (p_pix_gap) else $error("luma strobes closer than a pixel edge");
  c_err: cover property (acc && pslverr_o);
  c_frame: cover property (frame_start_o);
  c_luma: cover property (pix_y_vld_o && pix_c_vld_o == 1'b0);
endmodule
bind camera_input_frontend_config camif_fe_checker camif_fe_checker_inst (.clock_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cam_reset_out_o, .iface_soft_reset_o,
  .frame_start_o, .pix_y_vld_o, .pix_c_vld_o);

//--- camera_source_model.sv
// Behavioural camera: pixel clock, vertical sync, line valid and data lanes, one frame per call.
// Assumes the caller waits for each frame; the pixel clock stands still between frames.
`timescale 1ns/1ps
module camera_source_model (
  output logic       pclk_o,
  output logic       vsync_o,
  output logic       href_o,
  output logic [7:0] luma_o,
  output logic [7:0] chroma_o
);
  initial begin
    pclk_o = 1'b0;
    vsync_o = 1'b0;
    href_o = 1'b0;
    luma_o = 8'h5a;
    chroma_o = 8'ha5;
  end
  // Idle lanes toggle so a stale byte can never pass for data
  task automatic tick();
    #80 pclk_o = 1'b1;
    #80 pclk_o = 1'b0;
    chroma_o = ~chroma_o;
    if (!href_o) luma_o = ~luma_o;
  endtask
  task automatic frame(input int n, input logic [7:0] base);
    vsync_o = 1'b1;
    repeat (2) tick();
    vsync_o = 1'b0;
    repeat (4) tick();
    href_o = 1'b1;
    for (int k = 0; k < n; k++) begin
      luma_o = base + 8'(k);
      tick();
    end
    href_o = 1'b0;
    repeat (2) tick();
  endtask
endmodule

//--- camera_input_frontend_config_tb_top.sv
// Bench of the camera front end: registers, overflow clears, byte order, soft reset, windowing.
// Assumes package, design, checker and camera model are compiled first.
`timescale 1ns/1ps
`include "camif_defines.svh"
module camera_input_frontend_config_tb_top;
  import camif_pkg::*;
  logic        clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [31:0] paddr_i = '0;
  word_t       pwdata_i = '0, prdata_o, sf;
  logic        pready_o, pslverr_o, cam_pixel_clock_i, cam_vertical_sync_i, cam_line_valid_i, pix_y_vld_o;
  logic        cam_reset_out_o, iface_soft_reset_o, frame_start_o, pix_c_vld_o, pix_c_is_cr_o;
  logic [7:0]  cam_luma_lane_i, cam_chroma_lane_i, pix_y_o, pix_c_o, yq[$];
  logic [4:0]  ovf_event_i = '0;
  logic [8:0]  cq[$];
  int          n_mismatch = 0, compares = 0, fs_n = 0;
  always #2.5 clock_i = ~clock_i;
  camera_input_frontend_config camera_input_frontend_config_inst (.clock_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cam_pixel_clock_i, .cam_vertical_sync_i,
    .cam_line_valid_i, .cam_luma_lane_i, .cam_chroma_lane_i, .ovf_event_i, .cam_reset_out_o, .iface_soft_reset_o,
    .frame_start_o, .pix_y_vld_o, .pix_y_o, .pix_c_vld_o, .pix_c_o, .pix_c_is_cr_o);
  camera_source_model camera_source_model_inst (.pclk_o(cam_pixel_clock_i), .vsync_o(cam_vertical_sync_i),
    .href_o(cam_line_valid_i), .luma_o(cam_luma_lane_i), .chroma_o(cam_chroma_lane_i));
  always @(posedge clock_i) begin
    if (pix_y_vld_o === 1'b1) yq.push_back(pix_y_o);
    if (pix_c_vld_o === 1'b1) cq.push_back({pix_c_is_cr_o, pix_c_o});
    if (frame_start_o === 1'b1) fs_n++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input word_t wd, output word_t d, output logic e);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    chk(n < 40, 1, "bus answer");
    d = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic bus_wr(input logic [31:0] a, input word_t v);
    word_t d;
    logic  e;
    apb(1'b1, a, v, d, e);
  endtask
  task automatic bus_rd(input logic [31:0] a, input word_t x, input logic xe);
    word_t d;
    logic  e;
    apb(1'b0, a, '0, d, e);
    chk(d, x, "read data");
    chk(e, xe, "slave error");
  endtask
  task automatic grab(input int n);
    bus_wr(`ADDR_CAPTURE_CONTROL, 32'h1);
    yq.delete();
    cq.delete();
    fs_n = 0;
    camera_source_model_inst.frame(n, 8'h20);
    repeat (20) @(posedge clock_i);
  endtask
  task automatic pulse();
    @(posedge clock_i);
    ovf_event_i <= 5'h1f;
    @(posedge clock_i);
    ovf_event_i <= 5'h00;
  endtask
  task automatic t_regs();
    bus_rd(`ADDR_SOURCE_FORMAT, 32'h0, 1'b0);
    bus_rd(`ADDR_WINDOW_OFFSET, 32'h0, 1'b0);
    bus_rd(`ADDR_GLOBAL_CONTROL, 32'h2000_0000, 1'b0);
    bus_rd(32'h4800_0014, 32'h0, 1'b1);
    bus_wr(`ADDR_SOURCE_FORMAT, 32'hffff_ffff);
    bus_rd(`ADDR_SOURCE_FORMAT, 32'hffff_dfff, 1'b0);
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'hc000_0000);
    repeat (2) @(posedge clock_i);
    chk({cam_reset_out_o, iface_soft_reset_o}, 2'b11, "control lines set");
    bus_rd(`ADDR_GLOBAL_CONTROL, 32'he000_0000, 1'b0);
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'h0);
    repeat (2) @(posedge clock_i);
    chk({cam_reset_out_o, iface_soft_reset_o}, 2'b00, "control lines clear");
  endtask
  task automatic t_ovf();
    pulse();
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h0);
    bus_rd(`ADDR_STATUS, 32'h1f, 1'b0);
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h4000_c000);
    bus_rd(`ADDR_STATUS, 32'h03, 1'b0);
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h0000_3000);
    bus_rd(`ADDR_STATUS, 32'h00, 1'b0);
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h0);
    pulse();
    bus_rd(`ADDR_STATUS, 32'h1f, 1'b0);
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h4000_f000);
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h0);
  endtask
  task automatic t_order();
    logic [7:0] b;
    int         yi, ci;
    for (int o = 0; o < 4; o++) begin
      sf = {1'b1, o[0], 1'b0, 13'd8, o[1:0], 1'b0, 13'd16};
      bus_wr(`ADDR_SOURCE_FORMAT, sf);
      grab(16);
      chk(fs_n, 1, "frame start");
      chk(yq.size(), 8, "luma count");
      chk(cq.size(), 8, "chroma count");
      yi = 0;
      ci = 0;
      for (int k = 0; k < 16; k++) begin
        b = 8'h20 + 8'(k);
        if (k[0] == o[1]) begin
          chk(yq[yi], b, "luma");
          yi++;
        end else begin
          chk(cq[ci], {o[0] ^ ci[0], b + (o[0] ? 8'h80 : 8'h00)}, "chroma");
          ci++;
        end
      end
    end
  endtask
  task automatic t_soft();
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'h8000_0000);
    grab(16);
    chk(yq.size() + cq.size(), 0, "pixels in soft reset");
    bus_rd(`ADDR_SOURCE_FORMAT, sf, 1'b0);
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'h0);
  endtask
  task automatic t_window();
    bus_wr(`ADDR_SOURCE_FORMAT, {3'b100, 13'd16, 3'b000, 13'd16});
    bus_wr(`ADDR_WINDOW_OFFSET, {1'b1, 4'h0, 11'd8, 16'h0});
    grab(32);
    chk(yq[0], 8'h30, "first luma after offset");
    bus_wr(`ADDR_WINDOW_OFFSET, 32'h0);
  endtask
  task automatic t_pattern();
    bus_wr(`ADDR_SOURCE_FORMAT, 32'h8008_0010);
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'h1000_0000);
    grab(16);
    chk(yq.size(), 8, "pattern luma count");
    for (int k = 0; k < 8; k++) begin
      chk(yq[k], 8'(k), "pattern luma");
    end
    chk(cq[0], {1'b0, 8'h80}, "pattern chroma");
    bus_wr(`ADDR_GLOBAL_CONTROL, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_ovf();
    t_order();
    t_soft();
    t_window();
    t_pattern();
    report_and_stop();
  end
  // About ten times the expected run, so only a real hang trips it
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
